//--- design/crp_regs.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module crp_regs
    import crp_pkg::*;
#(
    parameter logic [15:0] FAMILY_ID = 16'h5A5A  // Arbitrary identity value
) (
    input  wire  logic        CLOCK,
    input  wire  logic        NRST,
    input  wire  logic [7:0]  ADDR,
    input  wire  logic [15:0] WDATA,
    input  wire  logic        WR,
    input  wire  logic        RD,
    output logic       [15:0] RDATA,
    input  wire  logic        HP_AUTO_POWERUP,
    input  wire  logic        OVERTEMP,
    output logic              SPK_R_ENABLE,
    output logic              SPK_L_ENABLE,
    output logic              EARPIECE_ENABLE,
    output logic       [1:0]  HP_L_STAGES,
    output logic       [1:0]  HP_R_STAGES,
    output logic              MICB2_OUT,
    output logic              MICB2_OE,
    output logic              MICB1_OUT,
    output logic              MICB1_OE,
    output logic              REF_DIV_NORMAL,
    output logic              REF_DIV_STANDBY,
    output logic              BIAS_ENABLE,
    output logic              GPIO_CLK_ENABLE,
    output logic              MIXIN_L_ENABLE,
    output logic              MIXIN_R_ENABLE,
    output logic              RECEIVE_VOICE_INPUT_L_ENABLE,
    output logic              RECEIVE_VOICE_INPUT_R_ENABLE,
    output logic       [3:0]  INPUT_AMP_ENABLE,
    output logic              ADC_L_ENABLE,
    output logic              ADC_R_ENABLE,
    output logic              OUTPUTS_CUT,
    output logic              IRQ
);

    initial begin
        if (FAMILY_ID == 16'h0000) $error("FAMILY_ID must be nonzero");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] pwr_out;
    logic [15:0] pwr_in;
    logic [15:0] seq_scratch;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [15:0] rdata;
    logic [2:0]  ot_sync;
    logic        ot_stable;
    logic        ot_prev;
    logic [15:0] next_pwr_out;
    logic [15:0] next_pwr_in;
    logic [15:0] next_seq_scratch;
    logic [2:0]  next_irq_status;
    logic [2:0]  next_irq_mask;
    logic [15:0] next_rdata;
    logic        next_ot_stable;
    logic        soft_reset;
    logic        cut;
    logic        ot_rise;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    assign soft_reset = WR && (ADDR == OFS_RESET_ID);
    assign cut        = pwr_in[BIT_TSENSE] && pwr_in[BIT_TCUTOFF] && ot_stable;
    assign ot_rise    = ot_stable && !ot_prev;

    always_comb begin
        next_pwr_out     = pwr_out;
        next_pwr_in      = pwr_in;
        next_seq_scratch = seq_scratch;
        next_irq_mask    = irq_mask;
        next_irq_status  = irq_status;
        next_rdata       = 16'h0000;
        next_ot_stable   = ot_stable;
        if (ot_sync[1] == ot_sync[2]) begin
            next_ot_stable = ot_sync[2];
        end
        if (soft_reset) begin
            next_pwr_out  = RST_PWR_OUTPUTS;
            next_pwr_in   = RST_PWR_INPUTS;
            next_irq_mask = RST_IRQ;
        end else if (WR) begin
            case (ADDR)
                OFS_PWR_OUTPUTS: next_pwr_out    = WDATA & MASK_PWR_OUTPUTS;
                OFS_PWR_INPUTS:  next_pwr_in     = WDATA & MASK_PWR_INPUTS;
                OFS_SEQ_SCRATCH: next_seq_scratch = WDATA;
                OFS_IRQ_MASK:    next_irq_mask   = WDATA[2:0];
                default: ;
            endcase
        end
        if (RD) begin
            case (ADDR)
                OFS_RESET_ID:    next_rdata = FAMILY_ID;
                OFS_PWR_OUTPUTS: next_rdata = pwr_out;
                OFS_PWR_INPUTS:  next_rdata = pwr_in;
                OFS_SEQ_SCRATCH: next_rdata = seq_scratch;
                OFS_IRQ_STATUS:  next_rdata = {13'h0000, irq_status};
                OFS_IRQ_MASK:    next_rdata = {13'h0000, irq_mask};
                default:         next_rdata = 16'h0000;
            endcase
            if (ADDR == OFS_IRQ_STATUS) begin
                next_irq_status = 3'h0;
            end
        end
        // Set wins over the read clear
        if (soft_reset) next_irq_status[IRQ_SOFT_RESET] = 1'b1;
        if (ot_rise)    next_irq_status[IRQ_OVERTEMP]   = 1'b1;
        if (ot_rise && pwr_in[BIT_TSENSE] && pwr_in[BIT_TCUTOFF]) begin
            next_irq_status[IRQ_THERM_CUT] = 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pwr_out     <= RST_PWR_OUTPUTS;
            pwr_in      <= RST_PWR_INPUTS;
            seq_scratch <= RST_SEQ_SCRATCH;
            irq_status  <= RST_IRQ;
            irq_mask    <= RST_IRQ;
            rdata       <= 16'h0000;
            ot_sync     <= 3'h0;
            ot_stable   <= 1'b0;
            ot_prev     <= 1'b0;
        end else begin
            pwr_out     <= next_pwr_out;
            pwr_in      <= next_pwr_in;
            seq_scratch <= next_seq_scratch;
            irq_status  <= next_irq_status;
            irq_mask    <= next_irq_mask;
            rdata       <= next_rdata;
            ot_sync     <= {ot_sync[1:0], OVERTEMP};
            ot_stable   <= next_ot_stable;
            ot_prev     <= ot_stable;
        end
    end

    // ------------------------------------------------------------
    // Enable decode
    // ------------------------------------------------------------
    crp_refdiv_type refdiv;
    assign refdiv = crp_refdiv_type'(pwr_out[BIT_REFDIV_LO +: 2]);

    assign RDATA            = rdata;
    assign SPK_R_ENABLE     = pwr_out[BIT_SPK_R] && !cut;
    assign SPK_L_ENABLE     = pwr_out[BIT_SPK_L] && !cut;
    assign EARPIECE_ENABLE  = pwr_out[BIT_EARPIECE] && !cut;
    assign HP_L_STAGES[0]   = pwr_out[BIT_HP_L] && !cut;
    assign HP_L_STAGES[1]   = pwr_out[BIT_HP_L] && HP_AUTO_POWERUP && !cut;
    assign HP_R_STAGES[0]   = pwr_out[BIT_HP_R] && !cut;
    assign HP_R_STAGES[1]   = pwr_out[BIT_HP_R] && HP_AUTO_POWERUP && !cut;
    assign MICB2_OUT        = pwr_out[BIT_MICB2];
    assign MICB2_OE         = pwr_out[BIT_MICB2];
    assign MICB1_OUT        = pwr_out[BIT_MICB1];
    assign MICB1_OE         = pwr_out[BIT_MICB1];
    assign REF_DIV_NORMAL   = (refdiv == CRP_REF_NORMAL);
    assign REF_DIV_STANDBY  = (refdiv == CRP_REF_STANDBY);
    assign BIAS_ENABLE      = pwr_out[BIT_BIAS];
    assign GPIO_CLK_ENABLE  = pwr_in[BIT_GPIO_CLK];
    assign MIXIN_L_ENABLE   = pwr_in[BIT_MIXIN_L];
    assign MIXIN_R_ENABLE   = pwr_in[BIT_MIXIN_R];
    assign RECEIVE_VOICE_INPUT_L_ENABLE = pwr_in[BIT_MIXIN_L];
    assign RECEIVE_VOICE_INPUT_R_ENABLE = pwr_in[BIT_MIXIN_R];
    assign INPUT_AMP_ENABLE = pwr_in[BIT_INAMP_LO +: 4];
    assign ADC_L_ENABLE     = pwr_in[BIT_ADC_L];
    assign ADC_R_ENABLE     = pwr_in[BIT_ADC_R];
    assign OUTPUTS_CUT      = cut;
    assign IRQ              = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_soft_reset_out: assert property (@(posedge CLOCK) disable iff (!NRST)
        soft_reset |=> (pwr_out == RST_PWR_OUTPUTS) && (pwr_in == RST_PWR_INPUTS))
        else $error("soft reset did not restore power registers");
    chk_seq_kept: assert property (@(posedge CLOCK) disable iff (!NRST)
        soft_reset |=> $stable(seq_scratch))
        else $error("soft reset disturbed sequencer register");
    chk_id_read: assert property (@(posedge CLOCK) disable iff (!NRST)
        (RD && ADDR == OFS_RESET_ID) |=> RDATA == FAMILY_ID)
        else $error("identity read wrong");
    chk_spk_enable: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_OUTPUTS && WDATA[BIT_SPK_R] && !cut) |=> SPK_R_ENABLE || cut)
        else $error("right speaker not enabled");
    chk_hp_auto: assert property (@(posedge CLOCK) disable iff (!NRST)
        HP_L_STAGES[1] |-> HP_L_STAGES[0] && HP_AUTO_POWERUP)
        else $error("headphone stages inconsistent");
    chk_micbias_hiz: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_OUTPUTS && !WDATA[BIT_MICB1]) |=> !MICB1_OE)
        else $error("mic bias not released");
    chk_thermal_cut: assert property (@(posedge CLOCK) disable iff (!NRST)
        (ot_rise && pwr_in[BIT_TSENSE] && pwr_in[BIT_TCUTOFF]) |-> !SPK_L_ENABLE && !EARPIECE_ENABLE)
        else $error("outputs live during overtemperature");
    chk_unused_zero: assert property (@(posedge CLOCK) disable iff (!NRST)
        (RD && ADDR == OFS_PWR_INPUTS) |=> (RDATA & ~MASK_PWR_INPUTS) == 16'h0000)
        else $error("unassigned bits read nonzero");
    chk_adc_write: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_INPUTS) |=> ADC_L_ENABLE == $past(WDATA[BIT_ADC_L]))
        else $error("left converter enable wrong");
    chk_adc_right: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_INPUTS) |=> ADC_R_ENABLE == $past(WDATA[BIT_ADC_R]))
        else $error("right converter enable wrong");
    chk_hp_right: assert property (@(posedge CLOCK) disable iff (!NRST)
        HP_R_STAGES[1] |-> HP_R_STAGES[0] && HP_AUTO_POWERUP)
        else $error("right headphone stages inconsistent");
    chk_spk_left: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_OUTPUTS && !WDATA[BIT_SPK_L]) |=> !SPK_L_ENABLE)
        else $error("left speaker not disabled");
    chk_earpiece_off: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_OUTPUTS && !WDATA[BIT_EARPIECE]) |=> !EARPIECE_ENABLE)
        else $error("earpiece stage not disabled");
    chk_micbias2_hiz: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_OUTPUTS && !WDATA[BIT_MICB2]) |=> !MICB2_OE)
        else $error("mic bias two not released");
    chk_refdiv_onehot: assert property (@(posedge CLOCK) disable iff (!NRST)
        !(REF_DIV_NORMAL && REF_DIV_STANDBY))
        else $error("both divider selects active");
    chk_refdiv_normal: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_OUTPUTS && WDATA[BIT_REFDIV_LO +: 2] == 2'h1) |=> REF_DIV_NORMAL)
        else $error("normal divider not selected");
    chk_bias_write: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_OUTPUTS) |=> BIAS_ENABLE == $past(WDATA[BIT_BIAS]))
        else $error("bias generator enable wrong");
    chk_gpio_clk: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_INPUTS) |=> GPIO_CLK_ENABLE == $past(WDATA[BIT_GPIO_CLK]))
        else $error("clock output enable wrong");
    chk_receive_voice_input_pair: assert property (@(posedge CLOCK) disable iff (!NRST)
        (RECEIVE_VOICE_INPUT_L_ENABLE == MIXIN_L_ENABLE) && (RECEIVE_VOICE_INPUT_R_ENABLE == MIXIN_R_ENABLE))
        else $error("receive voice not paired with mixer");
    chk_input_amps: assert property (@(posedge CLOCK) disable iff (!NRST)
        (WR && ADDR == OFS_PWR_INPUTS) |=> INPUT_AMP_ENABLE == $past(WDATA[BIT_INAMP_LO +: 4]))
        else $error("input amplifier enables wrong");
    chk_cut_outputs: assert property (@(posedge CLOCK) disable iff (!NRST)
        OUTPUTS_CUT |-> !SPK_R_ENABLE && !SPK_L_ENABLE && HP_L_STAGES == 2'h0 && HP_R_STAGES == 2'h0)
        else $error("audio outputs live while cut");
    chk_soft_reset_irq: assert property (@(posedge CLOCK) disable iff (!NRST)
        soft_reset |=> (irq_mask == RST_IRQ) && irq_status[IRQ_SOFT_RESET])
        else $error("soft reset did not restore interrupt state");
    chk_unused_out: assert property (@(posedge CLOCK) disable iff (!NRST)
        (RD && ADDR == OFS_PWR_OUTPUTS) |=> (RDATA & ~MASK_PWR_OUTPUTS) == 16'h0000)
        else $error("unassigned output bits read nonzero");
    chk_rdata_idle: assert property (@(posedge CLOCK) disable iff (!NRST)
        !RD |=> RDATA == 16'h0000)
        else $error("read data not cleared");

    cov_soft_reset: cover property (@(posedge CLOCK) disable iff (!NRST) soft_reset);
    cov_thermal:    cover property (@(posedge CLOCK) disable iff (!NRST) ot_rise && cut);
    cov_irq:        cover property (@(posedge CLOCK) disable iff (!NRST) $rose(IRQ));
    cov_hp_auto:    cover property (@(posedge CLOCK) disable iff (!NRST) HP_L_STAGES == 2'h3);
    cov_standby:    cover property (@(posedge CLOCK) disable iff (!NRST) REF_DIV_STANDBY);

endmodule : crp_regs

//--- design/crp_pkg.sv
package crp_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_RESET_ID     = 8'h00;
    localparam logic [7:0]  OFS_PWR_OUTPUTS  = 8'h01;
    localparam logic [7:0]  OFS_PWR_INPUTS   = 8'h02;
    localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK     = 8'h11;
    localparam logic [7:0]  OFS_SEQ_SCRATCH  = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_SPK_R      = 13;
    localparam int BIT_SPK_L      = 12;
    localparam int BIT_EARPIECE   = 11;
    localparam int BIT_HP_L       = 9;
    localparam int BIT_HP_R       = 8;
    localparam int BIT_MICB2      = 5;
    localparam int BIT_MICB1      = 4;
    localparam int BIT_REFDIV_LO  = 1;
    localparam int BIT_BIAS       = 0;
    localparam int BIT_TSENSE     = 14;
    localparam int BIT_TCUTOFF    = 13;
    localparam int BIT_GPIO_CLK   = 11;
    localparam int BIT_MIXIN_L    = 9;
    localparam int BIT_MIXIN_R    = 8;
    localparam int BIT_INAMP_LO   = 4;
    localparam int BIT_ADC_L      = 1;
    localparam int BIT_ADC_R      = 0;

    // Writable bits; all others read as zero
    localparam logic [15:0] MASK_PWR_OUTPUTS = 16'h3B37;
    localparam logic [15:0] MASK_PWR_INPUTS  = 16'h6BF3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_PWR_OUTPUTS  = 16'h0000;
    localparam logic [15:0] RST_PWR_INPUTS   = 16'h6000;
    localparam logic [15:0] RST_SEQ_SCRATCH  = 16'h0000;
    localparam logic [2:0]  RST_IRQ          = 3'h0;

    // Interrupt status bits
    localparam int IRQ_SOFT_RESET = 0;
    localparam int IRQ_OVERTEMP   = 1;
    localparam int IRQ_THERM_CUT  = 2;

    // Reference divider select
    typedef enum logic [1:0] {
        CRP_REF_OFF     = 2'h0,
        CRP_REF_NORMAL  = 2'h1,
        CRP_REF_STANDBY = 2'h2,
        CRP_REF_RSVD    = 2'h3
    } crp_refdiv_type;

endpackage : crp_pkg

//--- verification/crp_regs_tb.sv
`timescale 1ns/1ps
module crp_regs_tb;
    import crp_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [15:0] FAM = 16'hC3A5;  // Arbitrary identity value
    logic        clock = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, hp_auto = 1'b0, overtemp = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, got;
    logic        spk_r, spk_l, ear, mb2, mb2_oe, mb1, mb1_oe, r_nrm, r_std, bias, gpio, mix_l, mix_r;
    logic        rx_l, rx_r, adc_l, adc_r, cut, irq;
    logic [1:0]  hp_l, hp_r;
    logic [3:0]  amp;
    int          err_count = 0, num_checks = 0, cycles = 0;
    wire  [15:0] view_out = {2'h0, spk_r, spk_l, ear, 1'b0, hp_l[0], hp_r[0], 2'h0, mb2_oe, mb1_oe, 1'b0, r_std, r_nrm, bias};
    wire  [15:0] view_in  = {4'h0, gpio, 1'b0, mix_l, mix_r, amp, 2'h0, adc_l, adc_r};

    always #12.5 clock = ~clock;

    crp_regs #(.FAMILY_ID(FAM)) dut (
        .CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .HP_AUTO_POWERUP(hp_auto), .OVERTEMP(overtemp), .SPK_R_ENABLE(spk_r), .SPK_L_ENABLE(spk_l),
        .EARPIECE_ENABLE(ear), .HP_L_STAGES(hp_l), .HP_R_STAGES(hp_r), .MICB2_OUT(mb2), .MICB2_OE(mb2_oe),
        .MICB1_OUT(mb1), .MICB1_OE(mb1_oe), .REF_DIV_NORMAL(r_nrm), .REF_DIV_STANDBY(r_std),
        .BIAS_ENABLE(bias), .GPIO_CLK_ENABLE(gpio), .MIXIN_L_ENABLE(mix_l), .MIXIN_R_ENABLE(mix_r),
        .RECEIVE_VOICE_INPUT_L_ENABLE(rx_l), .RECEIVE_VOICE_INPUT_R_ENABLE(rx_r), .INPUT_AMP_ENABLE(amp), .ADC_L_ENABLE(adc_l),
        .ADC_R_ENABLE(adc_r), .OUTPUTS_CUT(cut), .IRQ(irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check_word(input logic [15:0] val, input logic [15:0] exp);
        num_checks++;
        if (val !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, val, exp);
        end
    endtask : check_word

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check_word(rdata, exp);
    endtask : reg_check

    // Waits a bounded time for the cutoff to reach a level
    task automatic wait_cut(input logic lvl);
        for (int n = 0; n < 10 && cut !== lvl; n++) begin
            @(posedge clock);
            #1;
        end
        check_word({15'h0, cut}, {15'h0, lvl});
    endtask : wait_cut

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        reg_check(OFS_RESET_ID, FAM);
        @(posedge clock);
        #1;
        check_word(rdata, 16'h0000);
        reg_check(OFS_PWR_OUTPUTS, 16'h0000);
        reg_check(OFS_PWR_INPUTS, 16'h6000);
        for (int i = 0; i < 16; i++) begin
            reg_write(OFS_PWR_OUTPUTS, 16'h1 << i);
            got = (16'h1 << i) & MASK_PWR_OUTPUTS;
            check_word(view_out, got);
            check_word({mb2, mb1, hp_l[1], hp_r[1]}, {got[5:4], 2'b00});
            reg_check(OFS_PWR_OUTPUTS, got);
            reg_write(OFS_PWR_INPUTS, 16'h1 << i);
            got = (16'h1 << i) & MASK_PWR_INPUTS;
            check_word(view_in, got & 16'h0BF3);
            check_word({rx_l, rx_r}, got[9:8]);
            reg_check(OFS_PWR_INPUTS, got);
        end
        for (int c = 0; c < 4; c++) begin
            reg_write(OFS_PWR_OUTPUTS, 16'(c) << 1);
            check_word({r_std, r_nrm}, (c == 1) ? 16'h1 : (c == 2) ? 16'h2 : 16'h0);
        end
        reg_write(OFS_PWR_INPUTS, 16'hFFFF);
        reg_check(OFS_PWR_INPUTS, 16'h6BF3);
        hp_auto <= 1'b1;
        reg_write(OFS_PWR_OUTPUTS, 16'h3B01);
        check_word({hp_l, hp_r}, 16'hF);
        reg_write(OFS_IRQ_MASK, 16'h0007);
        check_word({15'h0, irq}, 16'h0000);
        overtemp <= 1'b1;
        wait_cut(1'b1);
        check_word(view_out, 16'h0001);
        @(posedge clock);
        #1;
        check_word({15'h0, irq}, 16'h0001);
        reg_check(OFS_IRQ_STATUS, 16'h0006);
        check_word({15'h0, irq}, 16'h0000);
        reg_write(OFS_PWR_INPUTS, 16'h2000);
        wait_cut(1'b0);
        check_word(view_out, 16'h3B01);
        overtemp <= 1'b0;
        reg_write(OFS_SEQ_SCRATCH, 16'hA5C3);
        reg_write(OFS_RESET_ID, 16'h1234);
        check_word({15'h0, irq}, 16'h0000);
        reg_check(OFS_PWR_OUTPUTS, 16'h0000);
        reg_check(OFS_PWR_INPUTS, 16'h6000);
        reg_check(OFS_IRQ_MASK, 16'h0000);
        reg_check(OFS_IRQ_STATUS, 16'h0001);
        reg_check(OFS_SEQ_SCRATCH, 16'hA5C3);
        reg_check(OFS_RESET_ID, FAM);
        check_word(view_out, 16'h0000);
        reg_write(8'h3F, 16'hFFFF);
        reg_check(8'h3F, 16'h0000);
        wrap_up();
    end

endmodule : crp_regs_tb
